// ==== dv/slew_cfg_assertions.sv ====
// Checker of the global slew configuration registers.
`timescale 1ns/1ps
module slew_cfg_assertions (
  input wire logic                         clk_sys,
  input wire logic                         rst_b,
  input wire slew_cfg_pkg::reg_access_t    access,
  input wire logic                         phase4_falling_slew_control,
  input wire logic                         phase4_forced_pwm,
  input wire logic [7:0]                   rdata,
  input wire slew_cfg_pkg::slew_settings_t settings,
  input wire logic                         rampdown_limit_heavy_load_only
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire w33 = access.wr_en && access.addr == 8'h33;
  wire w34 = access.wr_en && access.addr == 8'h34;
  wire w35 = access.wr_en && access.addr == 8'h35;
  function automatic logic [2:0] sat(logic [2:0] c);
    return (c == 3'h7) ? 3'h6 : c;
  endfunction
  shutdown_write_a: assert property (w33 |=> settings[13:11] == sat($past(access.wdata[6:4])))
    else $error("shutdown slew wrong");
  softstart_write_a: assert property (w33 |=> settings[10:8] == sat($past(access.wdata[2:0])))
    else $error("softstart slew wrong");
  rampdown_write_a: assert property (w34 |=> settings[7:5] == sat($past(access.wdata[6:4])))
    else $error("rampdown slew wrong");
  rampup_write_a: assert property (w34 |=> settings[4:2] == sat($past(access.wdata[2:0])))
    else $error("rampup slew wrong");
  pos_boost_a: assert property (w35 |=> settings[1] == $past(access.wdata[1]))
    else $error("positive boost wrong");
  neg_boost_a: assert property (w35 |=> settings[0] == $past(access.wdata[0]))
    else $error("negative boost wrong");
  transient_read_a: assert property (access.rd_en && access.addr == 8'h35 |=> rdata[7:2] == 6'h17)
    else $error("transient reserved bits wrong");
  reserved_read_a: assert property (access.rd_en && access.addr >= 8'h36 |=> rdata == 8'h00)
    else $error("reserved read not zero");
  reserved_write_a: assert property (access.wr_en && access.addr >= 8'h36 |=> $stable(settings))
    else $error("reserved write changed settings");
  heavy_load_a: assert property (rampdown_limit_heavy_load_only ==
    !(phase4_falling_slew_control || phase4_forced_pwm)) else $error("heavy load flag wrong");
  cover property (w34 && access.wdata[6:4] == 3'h7);
  cover property (access.rd_en && access.addr >= 8'h36);
  cover property (w35 && !access.wdata[1]);
endmodule
bind buck_global_slew_config_regs slew_cfg_assertions chk (.clk_sys(clk_sys), .rst_b(rst_b), .access(access),
  .phase4_falling_slew_control(phase4_falling_slew_control), .phase4_forced_pwm(phase4_forced_pwm),
  .rdata(rdata), .settings(settings), .rampdown_limit_heavy_load_only(rampdown_limit_heavy_load_only));

// ==== dv/slew_host.sv ====
// Host model that issues register requests.
`timescale 1ns/1ps
module slew_host (
  input  wire logic                 clk_sys,
  output slew_cfg_pkg::reg_access_t access
);
  initial begin
    access = '0;
  end
  task automatic xfer(slew_cfg_pkg::reg_access_t req);
    @(posedge clk_sys);
    access <= req;
  endtask
endmodule

// ==== dv/test_buck_global_slew_config_regs.sv ====
// Testbench of the global slew configuration registers.
`timescale 1ns/1ps
module test_buck_global_slew_config_regs;
  logic                         clk_sys = 1'b0, rst_b = 1'b0, fsc = 1'b0, fpwm = 1'b0, hl;
  slew_cfg_pkg::reg_access_t    access;
  logic [7:0]                   rdata;
  slew_cfg_pkg::slew_settings_t settings;
  int                           bad_count = 0, n_checks = 0;
  logic [7:0]                   m [3] = '{8'h24, 8'h24, 8'h5f};
  slew_host host (.clk_sys(clk_sys), .access(access));
  buck_global_slew_config_regs dut (.clk_sys(clk_sys), .rst_b(rst_b), .access(access),
    .phase4_falling_slew_control(fsc), .phase4_forced_pwm(fpwm), .rdata(rdata), .settings(settings),
    .rampdown_limit_heavy_load_only(hl));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  function automatic logic [2:0] sat(logic [2:0] c);
    return (c == 3'h7) ? 3'h6 : c;
  endfunction
  task automatic check_rdata(logic [7:0] e);
    n_checks++;
    if (rdata !== e) begin
      bad_count++;
      $display("ERROR rdata expected %h seen %h", e, rdata);
    end
  endtask
  task automatic check_settings(logic [13:0] e);
    n_checks++;
    if (settings !== e) begin
      bad_count++;
      $display("ERROR settings expected %h seen %h", e, settings);
    end
  endtask
  task automatic check_heavy(logic e);
    n_checks++;
    if (hl !== e) begin
      bad_count++;
      $display("ERROR heavy expected %h seen %h", e, hl);
    end
  endtask
  task automatic op(logic w, logic [7:0] a, logic [7:0] d);
    logic [13:0] exp_settings;
    if (w && (a == 8'h33 || a == 8'h34)) d = d & 8'h77;
    if (w && a == 8'h35) d = (d & 8'h03) | 8'h5c;
    host.xfer('{w, !w, a, d});
    {fsc, fpwm} <= 2'($urandom);
    host.xfer('{1'b0, 1'b0, ~a, ~d});
    #1;
    if (w && a >= 8'h33 && a <= 8'h35) m[a - 8'h33] = (a == 8'h35) ? (d & 8'h03) | 8'h5c : d & 8'h77;
    if (!w) check_rdata((a >= 8'h33 && a <= 8'h35) ? m[a - 8'h33] : 8'h00);
    exp_settings = {sat(m[0][6:4]), sat(m[0][2:0]), sat(m[1][6:4]), sat(m[1][2:0]), m[2][1:0]};
    check_settings(exp_settings);
    check_heavy(!(fsc || fpwm));
  endtask
  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h13e9));
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) op(1'b0, 8'h33 + i[7:0], 8'h00);
    for (int c = 0; c < 8; c++) begin
      op(1'b1, 8'h33, {1'b0, c[2:0], 1'b0, c[2:0]});
      op(1'b1, 8'h34, {1'b0, c[2:0], 1'b0, c[2:0]});
      op(1'b1, 8'h35, {6'h17, c[1:0]});
    end
    for (int i = 0; i < 90; i++) op(1'($urandom), 8'($urandom_range(8'h32, 8'h38)), 8'($urandom));
    for (int i = 0; i < 6; i++) op(i[0], 8'($urandom_range(8'h36, 8'hff)), 8'($urandom));
    // A second reset in mid-run brings every register back to its default.
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    m = '{8'h24, 8'h24, 8'h5f};
    for (int i = 0; i < 3; i++) op(1'b0, 8'h33 + i[7:0], 8'h00);
    summarize();
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end
endmodule

// ==== hw/buck_global_slew_config_regs.sv ====
// Global slew and transient response configuration registers of the buck regulator.
`timescale 1ns/1ps
module buck_global_slew_config_regs (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire slew_cfg_pkg::reg_access_t     access,
  input  wire logic                          phase4_falling_slew_control,
  input  wire logic                          phase4_forced_pwm,
  output logic [7:0]                         rdata,
  output slew_cfg_pkg::slew_settings_t       settings,
  output logic                               rampdown_limit_heavy_load_only
);

  // ****************************************
  // Declarations
  // ****************************************
  // Reset values of the decoded slew settings follow the register reset values.
  localparam slew_cfg_pkg::slew_rate_t RESET_SHUTDOWN_RATE = slew_cfg_pkg::slew_rate_t'(
    slew_cfg_pkg::RESET_STARTUP_SHUTDOWN[slew_cfg_pkg::HIGH_FIELD_LSB +: slew_cfg_pkg::FIELD_W]);
  localparam slew_cfg_pkg::slew_rate_t RESET_SOFTSTART_RATE = slew_cfg_pkg::slew_rate_t'(
    slew_cfg_pkg::RESET_STARTUP_SHUTDOWN[slew_cfg_pkg::LOW_FIELD_LSB +: slew_cfg_pkg::FIELD_W]);
  localparam slew_cfg_pkg::slew_rate_t RESET_RAMPDOWN_RATE = slew_cfg_pkg::slew_rate_t'(
    slew_cfg_pkg::RESET_RAMP[slew_cfg_pkg::HIGH_FIELD_LSB +: slew_cfg_pkg::FIELD_W]);
  localparam slew_cfg_pkg::slew_rate_t RESET_RAMPUP_RATE = slew_cfg_pkg::slew_rate_t'(
    slew_cfg_pkg::RESET_RAMP[slew_cfg_pkg::LOW_FIELD_LSB +: slew_cfg_pkg::FIELD_W]);

  logic [7:0]               startup_shutdown_slew_config;
  logic [7:0]               ramp_slew_config;
  logic [1:0]               transient_response_config;
  logic [7:0]               next_startup_shutdown_slew_config;
  logic [7:0]               next_ramp_slew_config;
  logic [1:0]               next_transient_response_config;
  logic [7:0]               transient_readback;
  logic [7:0]               next_rdata;
  logic                     sel_startup_shutdown;
  logic                     sel_ramp;
  logic                     sel_transient;
  logic                     sel_reserved;
  logic                     hit_startup_shutdown;
  logic                     hit_ramp;
  logic                     hit_transient;
  logic [2:0]               shutdown_code;
  logic [2:0]               softstart_code;
  logic [2:0]               rampdown_code;
  logic [2:0]               rampup_code;
  slew_cfg_pkg::slew_rate_t next_shutdown_rate;
  slew_cfg_pkg::slew_rate_t next_softstart_rate;
  slew_cfg_pkg::slew_rate_t next_rampdown_rate;
  slew_cfg_pkg::slew_rate_t next_rampup_rate;
  slew_cfg_pkg::slew_rate_t shutdown_rate;
  slew_cfg_pkg::slew_rate_t softstart_rate;
  slew_cfg_pkg::slew_rate_t rampdown_rate;
  slew_cfg_pkg::slew_rate_t rampup_rate;

  // ****************************************
  // Address decode
  // ****************************************
  assign sel_startup_shutdown = (access.addr == slew_cfg_pkg::ADDR_STARTUP_SHUTDOWN);
  assign sel_ramp             = (access.addr == slew_cfg_pkg::ADDR_RAMP);
  assign sel_transient        = (access.addr == slew_cfg_pkg::ADDR_TRANSIENT);
  // Everything from the first reserved address upward holds no configuration.
  assign sel_reserved         = (access.addr >= slew_cfg_pkg::ADDR_RESERVED_FIRST);

  assign hit_startup_shutdown = access.wr_en && sel_startup_shutdown;
  assign hit_ramp             = access.wr_en && sel_ramp;
  assign hit_transient        = access.wr_en && sel_transient;

  // ****************************************
  // Next register values
  // ****************************************
  // Reserved bits of the slew registers are dropped, so they always read zero.
  assign next_startup_shutdown_slew_config =
    hit_startup_shutdown ? (access.wdata & slew_cfg_pkg::SLEW_REG_MASK) : startup_shutdown_slew_config;
  assign next_ramp_slew_config =
    hit_ramp ? (access.wdata & slew_cfg_pkg::SLEW_REG_MASK) : ramp_slew_config;
  // Only the two enables of the transient register hold storage.
  assign next_transient_response_config =
    hit_transient ? access.wdata[slew_cfg_pkg::POS_BOOST_BIT:slew_cfg_pkg::NEG_BOOST_BIT]
                  : transient_response_config;

  // ****************************************
  // Read data selection
  // ****************************************
  // The transient register reads its fixed reserved pattern around the two enables.
  assign transient_readback = (slew_cfg_pkg::TRANSIENT_RSVD_VALUE & slew_cfg_pkg::TRANSIENT_RSVD_MASK)
                            | {6'h00, transient_response_config};
  // Reserved addresses and unmapped ones read zero and ignore writes.
  assign next_rdata =
    sel_reserved         ? 8'h00 :
    sel_startup_shutdown ? startup_shutdown_slew_config :
    sel_ramp             ? ramp_slew_config :
    sel_transient        ? transient_readback :
    8'h00;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      startup_shutdown_slew_config <= slew_cfg_pkg::RESET_STARTUP_SHUTDOWN;
    end else begin
      startup_shutdown_slew_config <= next_startup_shutdown_slew_config;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ramp_slew_config <= slew_cfg_pkg::RESET_RAMP;
    end else begin
      ramp_slew_config <= next_ramp_slew_config;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transient_response_config <= slew_cfg_pkg::RESET_TRANSIENT[1:0];
    end else begin
      transient_response_config <= next_transient_response_config;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (access.rd_en) begin
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  assign shutdown_code  = next_startup_shutdown_slew_config[slew_cfg_pkg::HIGH_FIELD_LSB +: slew_cfg_pkg::FIELD_W];
  assign softstart_code = next_startup_shutdown_slew_config[slew_cfg_pkg::LOW_FIELD_LSB +: slew_cfg_pkg::FIELD_W];
  assign rampdown_code  = next_ramp_slew_config[slew_cfg_pkg::HIGH_FIELD_LSB +: slew_cfg_pkg::FIELD_W];
  assign rampup_code    = next_ramp_slew_config[slew_cfg_pkg::LOW_FIELD_LSB +: slew_cfg_pkg::FIELD_W];

  slew_code_decode u_shutdown (
    .code (shutdown_code),
    .rate (next_shutdown_rate)
  );

  slew_code_decode u_softstart (
    .code (softstart_code),
    .rate (next_softstart_rate)
  );

  slew_code_decode u_rampdown (
    .code (rampdown_code),
    .rate (next_rampdown_rate)
  );

  slew_code_decode u_rampup (
    .code (rampup_code),
    .rate (next_rampup_rate)
  );

  // ****************************************
  // Decoded setting registers
  // ****************************************
  // The decoded rates are held in flip-flops that load together with their register.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shutdown_rate <= RESET_SHUTDOWN_RATE;
    end else begin
      shutdown_rate <= next_shutdown_rate;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      softstart_rate <= RESET_SOFTSTART_RATE;
    end else begin
      softstart_rate <= next_softstart_rate;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rampdown_rate <= RESET_RAMPDOWN_RATE;
    end else begin
      rampdown_rate <= next_rampdown_rate;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rampup_rate <= RESET_RAMPUP_RATE;
    end else begin
      rampup_rate <= next_rampup_rate;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign settings = '{
    shutdown_slew_select:            shutdown_rate,
    softstart_slew_select:           softstart_rate,
    rampdown_slew_select:            rampdown_rate,
    rampup_slew_select:              rampup_rate,
    positive_transient_boost_enable: transient_response_config[slew_cfg_pkg::POS_BOOST_BIT],
    negative_transient_boost_enable: transient_response_config[slew_cfg_pkg::NEG_BOOST_BIT]
  };

  // ****************************************
  // Ramp-down load dependence
  // ****************************************
  // The ramp-down rate only binds under heavy load when the phase may skip.
  assign rampdown_limit_heavy_load_only = !phase4_falling_slew_control && !phase4_forced_pwm;

endmodule

// ==== hw/slew_cfg_pkg.sv ====
// Package with register map, field layout and encodings of the global slew configuration block.
package slew_cfg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_STARTUP_SHUTDOWN = 8'h33;
  localparam logic [7:0] ADDR_RAMP             = 8'h34;
  localparam logic [7:0] ADDR_TRANSIENT        = 8'h35;
  localparam logic [7:0] ADDR_RESERVED_FIRST   = 8'h36;

  localparam logic [7:0] RESET_STARTUP_SHUTDOWN = 8'h24;
  localparam logic [7:0] RESET_RAMP             = 8'h24;
  localparam logic [7:0] RESET_TRANSIENT        = 8'h5f;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int HIGH_FIELD_LSB  = 4;
  localparam int LOW_FIELD_LSB   = 0;
  localparam int FIELD_W         = 3;
  localparam int POS_BOOST_BIT   = 1;
  localparam int NEG_BOOST_BIT   = 0;

  // Bits of the slew registers that hold storage; bits 7 and 3 read zero.
  localparam logic [7:0] SLEW_REG_MASK = 8'h77;
  // Reserved bits of the transient register read their fixed reset pattern.
  localparam logic [7:0] TRANSIENT_RSVD_MASK  = 8'hfc;
  localparam logic [7:0] TRANSIENT_RSVD_VALUE = 8'h5c;

  // ****************************************
  // Slew rate encodings
  // ****************************************
  typedef enum logic [2:0] {
    RATE_1P25 = 3'h0,
    RATE_2P5  = 3'h1,
    RATE_5    = 3'h2,
    RATE_10   = 3'h3,
    RATE_20   = 3'h4,
    RATE_40   = 3'h5,
    RATE_60   = 3'h6
  } slew_rate_t;

  localparam logic [2:0] CODE_UNLISTED = 3'h7;

  // Register access carried as one bundle.
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  // Decoded settings delivered to the regulator.
  typedef struct packed {
    slew_rate_t shutdown_slew_select;
    slew_rate_t softstart_slew_select;
    slew_rate_t rampdown_slew_select;
    slew_rate_t rampup_slew_select;
    logic       positive_transient_boost_enable;
    logic       negative_transient_boost_enable;
  } slew_settings_t;

endpackage

// ==== hw/slew_code_decode.sv ====
// Decoder from a three-bit slew code to a slew rate.
`timescale 1ns/1ps
module slew_code_decode (
  input  wire logic [2:0]               code,
  output slew_cfg_pkg::slew_rate_t      rate
);

  // ****************************************
  // Decode
  // ****************************************
  // The unlisted code runs at the fastest rate.
  assign rate = (code == slew_cfg_pkg::CODE_UNLISTED) ? slew_cfg_pkg::RATE_60
                                                      : slew_cfg_pkg::slew_rate_t'(code);

endmodule
